// ==== include/lcs_defines.svh ====
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH
// ****************************************
// sizes
// ****************************************
`define LCS_NCH          6
`define LCS_NOUT         26
`define LCS_ALL_CH       6'h3f
`define LCS_NO_CH        6'h00
// ****************************************
// register addresses
// ****************************************
`define LCS_A_CHAN_LIST  8'h01
`define LCS_A_CHCFG0     8'h02
`define LCS_A_CHCFG5     8'h07
`define LCS_A_COUNT0     8'h08
`define LCS_A_COUNT2     8'h0a
`define LCS_A_PERIOD_H   8'h0b
`define LCS_A_PERIOD_L   8'h0c
`define LCS_A_BURST      8'h0d
`define LCS_A_IRQ_EN     8'h0e
`define LCS_A_COMMAND    8'h0f
`define LCS_A_RESPONSE   8'h10
`define LCS_A_FLAGS      8'h12
`define LCS_A_OUT_FIRST  8'h13
`define LCS_A_OUT_LAST   8'h2c
// ****************************************
// fields, commands, codes
// ****************************************
`define LCS_CFG_FMT24    2
`define LCS_CFG_CNT_HI   1
`define LCS_CFG_CNT_LO   0
`define LCS_BURST_EN     7
`define LCS_BURST_CNT_HI 6
`define LCS_CMD_RST_CTR  8'h01
`define LCS_CMD_FORCE    8'h02
`define LCS_CMD_PAUSE    8'h03
`define LCS_CMD_START    8'h04
`define LCS_ERR_OVERFLOW 8'h13
`define LCS_CTR_RESET    4'hf
`define LCS_W16          7'h02
`define LCS_W24          7'h03
// ****************************************
// timing
// ****************************************
`define LCS_CLK_NS       25
`define LCS_TICK_NS      800000
`endif

// ==== include/lcs_pkg.sv ====
package lcs_pkg;
  typedef enum logic [1:0] {
    lcs_st_idle   = 2'b00,
    lcs_st_busy   = 2'b01,
    lcs_st_commit = 2'b10,
    lcs_st_flags  = 2'b11
  } lcs_state_type;

  typedef struct packed {
    logic       start;
    logic [2:0] chan;
  } lcs_meas_req_type;

  typedef struct packed {
    logic        done;
    logic [23:0] result;
  } lcs_meas_ans_type;
endpackage : lcs_pkg

// ==== src/lcs_scheduler.sv ====
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "lcs_defines.svh"
// How it works
// RULE1 - only channels in the enable list are measured and decide packing
// RULE2 - results pack upward from the first byte, lowest channel first, no gaps
// RULE3 - each enabled channel takes two or three bytes by its format bit
// RULE4 - most significant byte lowest, then middle, then least significant
// RULE5 - placement depends on list and formats only, not on flags or mask
// RULE6 - valid data follows flags, forced batch end, or whole burst end
// RULE7 - burst repeats the channel set at higher addresses without padding
// RULE8 - autonomous channel starts a measurement when its own timer trips
// RULE9 - after completion is flagged the channel timer restarts
// RULE10 - host must read an autonomous result before the next one lands
// RULE11 - force runs every enabled channel without a rate counter once, lowest first, back to back
// RULE12 - forced results flag all their channels in the same cycle
// RULE13 - force acts only on channels with no rate counter selected
// RULE14 - burst control bit 7 enables burst, bits 6:0 give set count
// RULE15 - burst runs all enabled channels on the group period, no counters
// RULE16 - start begins a burst, pause suspends it, sets repeat per period
// RULE17 - within a burst set channels run consecutively lowest to highest
// RULE18 - burst ends at count or full field, then flags every enabled channel
// RULE19 - burst copies all output bytes first, flags and interrupt after
// RULE20 - interrupt rises when a flagged channel has its enable bit set
// RULE21 - reading the flag register clears all flag bits
// RULE22 - host should read flags and results in one sequential read
// RULE23 - flag bits 0 to 5 mark channel results ready, at address 0x12
// RULE24 - one group period count stands for 800 us
// RULE25 - burst larger than the output field reports error code 0x13
// RULE26 - clear on read acts after the byte is returned; new sets survive
module lcs_scheduler #(
  parameter int unsigned TICK_CYCLES = `LCS_TICK_NS / `LCS_CLK_NS
) (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic [7:0]                addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic [7:0]                     rdata,
  output lcs_pkg::lcs_meas_req_type      meas_req,
  input  wire lcs_pkg::lcs_meas_ans_type meas_ans,
  output logic                           irq
);
  // ****************************************
  // storage
  // ****************************************
  logic [5:0]  chan_list;
  logic [7:0]  chcfg [`LCS_NCH];
  logic [7:0]  meas_count [3];
  logic [15:0] group_period;
  logic [7:0]  burst_cfg;
  logic [5:0]  irq_en;
  logic [5:0]  flags;
  logic [7:0]  out_buf [`LCS_NOUT];
  logic [7:0]  shadow [`LCS_NOUT];
  logic [7:0]  response;
  logic        auto_on;
  logic        burst_on;
  logic        paused;
  logic [5:0]  force_mask;
  logic [6:0]  base;
  logic [6:0]  sets;
  logic [5:0]  pending;
  logic [2:0]  cur;
  logic [5:0]  waiting;
  logic [7:0]  ch_cnt [`LCS_NCH];
  logic [31:0] tick_cnt;
  logic [15:0] grp_cnt;
  lcs_pkg::lcs_state_type state;

  // ****************************************
  // packing arithmetic
  // ****************************************
  function automatic logic [6:0] chan_offset(input logic [5:0] list,
                                             input logic [5:0] fmt,
                                             input int         ch);
    logic [6:0] sum;
    sum = 7'h00;
    for (int i = 0; i < `LCS_NCH; i++) begin
      if (i < ch && list[i]) begin
        sum = sum + (fmt[i] ? `LCS_W24 : `LCS_W16);
      end
    end
    return sum;
  endfunction : chan_offset

  function automatic logic [2:0] lowest(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = `LCS_NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : lowest

  logic [5:0]  fmt24;
  logic [5:0]  no_ctr;
  logic [6:0]  set_size;
  logic [6:0]  wr_off;
  logic [23:0] res;
  logic        done_fire;
  logic [5:0]  cur_bit;
  logic        set_end;
  logic        burst_last;
  logic        force_end;
  logic        cmd_wr;
  logic        running;
  logic        tick;
  logic        grp;
  logic [5:0]  trip;
  logic [5:0]  flag_set;
  logic [5:0]  flag_clr;
  logic [13:0] burst_need;

  always_comb begin
    for (int i = 0; i < `LCS_NCH; i++) begin
      fmt24[i]  = chcfg[i][`LCS_CFG_FMT24];
      no_ctr[i] = chcfg[i][`LCS_CFG_CNT_HI:`LCS_CFG_CNT_LO] == 2'b00;
    end
  end

  assign set_size  = chan_offset(chan_list, fmt24, `LCS_NCH);
  assign done_fire = state == lcs_pkg::lcs_st_busy && meas_ans.done;
  assign cur_bit   = 6'h01 << cur;
  assign res       = meas_ans.result;
  // placement only reads list and formats, never flags or irq mask
  assign wr_off    = (burst_on ? base : 7'h00)
                   + chan_offset(chan_list, fmt24, int'(cur)); // RULE2 RULE5 RULE7
  assign set_end   = done_fire && burst_on && (pending & ~cur_bit) == 6'h00;
  assign burst_last = {1'b0, sets} + 8'h01
                      >= {1'b0, burst_cfg[`LCS_BURST_CNT_HI:0]}
                   || {1'b0, base} + {set_size, 1'b0}
                      > 8'(`LCS_NOUT); // RULE18
  assign force_end = done_fire && !burst_on && (force_mask & cur_bit) != 0
                   && (force_mask & pending & ~cur_bit) == 6'h00;
  assign cmd_wr    = wr_en && addr == `LCS_A_COMMAND;
  assign running   = (auto_on || burst_on) && !paused;
  assign burst_need = 14'(burst_cfg[`LCS_BURST_CNT_HI:0]) * 14'(set_size);

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chan_list    <= `LCS_NO_CH;
      group_period <= 16'h0000;
      burst_cfg    <= 8'h00;
      irq_en       <= `LCS_NO_CH;
      for (int i = 0; i < `LCS_NCH; i++) begin
        chcfg[i] <= 8'h00;
      end
      for (int i = 0; i < 3; i++) begin
        meas_count[i] <= 8'h00;
      end
    end else if (wr_en) begin
      if (addr == `LCS_A_CHAN_LIST) begin
        chan_list <= wdata[5:0]; // RULE1
      end else if (addr >= `LCS_A_CHCFG0 && addr <= `LCS_A_CHCFG5) begin
        chcfg[3'(addr - `LCS_A_CHCFG0)] <= wdata;
      end else if (addr >= `LCS_A_COUNT0 && addr <= `LCS_A_COUNT2) begin
        meas_count[2'(addr - `LCS_A_COUNT0)] <= wdata;
      end else if (addr == `LCS_A_PERIOD_H) begin
        group_period[15:8] <= wdata;
      end else if (addr == `LCS_A_PERIOD_L) begin
        group_period[7:0] <= wdata;
      end else if (addr == `LCS_A_BURST) begin
        burst_cfg <= wdata; // RULE14
      end else if (addr == `LCS_A_IRQ_EN) begin
        irq_en <= wdata[5:0];
      end
    end
  end

  // ****************************************
  // commands and modes
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      auto_on    <= 1'b0;
      burst_on   <= 1'b0;
      paused     <= 1'b0;
      force_mask <= `LCS_NO_CH;
      base       <= 7'h00;
      sets       <= 7'h00;
      response   <= {4'h0, `LCS_CTR_RESET};
    end else begin
      if (cmd_wr && wdata == `LCS_CMD_START) begin
        paused <= 1'b0; // RULE16
        if (!auto_on && !burst_on) begin
          base <= 7'h00;
          sets <= 7'h00;
          if (burst_cfg[`LCS_BURST_EN]) begin
            burst_on <= 1'b1; // RULE14
          end else begin
            auto_on <= 1'b1;
          end
          if (burst_cfg[`LCS_BURST_EN] && burst_need > 14'(`LCS_NOUT)) begin
            response <= `LCS_ERR_OVERFLOW; // RULE25
          end
        end
      end else if (cmd_wr && wdata == `LCS_CMD_PAUSE) begin
        paused <= 1'b1; // RULE16
      end else if (cmd_wr && wdata == `LCS_CMD_FORCE) begin
        force_mask <= chan_list & no_ctr; // RULE13
      end else if (cmd_wr && wdata == `LCS_CMD_RST_CTR) begin
        response <= 8'h00;
      end
      if (set_end) begin
        base <= base + set_size; // RULE7
        sets <= sets + 7'h01;
      end
      if (force_end) begin
        force_mask <= `LCS_NO_CH;
      end
      if (state == lcs_pkg::lcs_st_flags) begin
        burst_on <= 1'b0;
      end
    end
  end

  // ****************************************
  // tick and group period
  // ****************************************
  assign tick = running && tick_cnt == TICK_CYCLES - 1;
  assign grp  = tick && {16'h0000, grp_cnt} + 32'h1 >= {16'h0000, group_period};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 32'h0;
      grp_cnt  <= 16'h0000;
    end else if (!running) begin
      tick_cnt <= 32'h0;
      grp_cnt  <= 16'h0000;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1; // RULE24
      if (grp) begin
        grp_cnt <= 16'h0000;
      end else if (tick) begin
        grp_cnt <= grp_cnt + 16'h0001;
      end
    end
  end

  // ****************************************
  // per-channel timers
  // ****************************************
  always_comb begin
    for (int i = 0; i < `LCS_NCH; i++) begin
      trip[i] = auto_on && grp && chan_list[i] && !no_ctr[i] && !waiting[i]
             && {1'b0, ch_cnt[i]} + 9'h001
                >= {1'b0, meas_count[chcfg[i][`LCS_CFG_CNT_HI:0] - 2'b01]};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waiting <= `LCS_NO_CH;
      for (int i = 0; i < `LCS_NCH; i++) begin
        ch_cnt[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < `LCS_NCH; i++) begin
        if (trip[i]) begin
          waiting[i] <= 1'b1; // RULE8
          ch_cnt[i]  <= 8'h00;
        end else if (done_fire && cur == 3'(i)) begin
          waiting[i] <= 1'b0; // RULE9
        end else if (!auto_on || paused) begin
          // timers start from zero on start and again on resume
          ch_cnt[i] <= 8'h00;
        end else if (grp && !waiting[i]) begin
          ch_cnt[i] <= ch_cnt[i] + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // measurement engine
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state    <= lcs_pkg::lcs_st_idle;
      pending  <= `LCS_NO_CH;
      cur      <= 3'h0;
      meas_req <= '0;
    end else begin
      meas_req.start <= 1'b0;
      case (state)
        lcs_pkg::lcs_st_idle: begin
          if (pending != `LCS_NO_CH) begin
            meas_req.start <= 1'b1; // RULE11 RULE17
            meas_req.chan  <= lowest(pending);
            cur            <= lowest(pending);
            state          <= lcs_pkg::lcs_st_busy;
          end
        end
        lcs_pkg::lcs_st_busy: begin
          if (done_fire) begin
            state <= (set_end && burst_last) ? lcs_pkg::lcs_st_commit
                                             : lcs_pkg::lcs_st_idle;
          end
        end
        lcs_pkg::lcs_st_commit: begin
          state <= lcs_pkg::lcs_st_flags; // RULE19
        end
        default: begin
          state <= lcs_pkg::lcs_st_idle;
        end
      endcase
      pending <= (pending & ~(done_fire ? cur_bit : `LCS_NO_CH))
               | trip
               | (cmd_wr && wdata == `LCS_CMD_FORCE ? chan_list & no_ctr
                                                    : `LCS_NO_CH) // RULE13
               // a group event that meets a set in flight is dropped, so
               // two sets never interleave
               | (burst_on && grp && pending == `LCS_NO_CH
                  && state == lcs_pkg::lcs_st_idle ? chan_list
                                                   : `LCS_NO_CH); // RULE15
    end
  end

  // ****************************************
  // result bytes
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `LCS_NOUT; i++) begin
        out_buf[i] <= 8'h00;
        shadow[i]  <= 8'h00;
      end
    end else if (state == lcs_pkg::lcs_st_commit) begin
      out_buf <= shadow; // RULE19
    end else if (done_fire && wr_off < 7'(`LCS_NOUT)) begin
      // msb lowest; 16-bit results drop the top byte
      if (burst_on) begin
        if (fmt24[cur]) begin
          shadow[5'(wr_off)]         <= res[23:16];
          shadow[5'(wr_off + 7'h01)] <= res[15:8];
          shadow[5'(wr_off + 7'h02)] <= res[7:0];
        end else begin
          shadow[5'(wr_off)]         <= res[15:8];
          shadow[5'(wr_off + 7'h01)] <= res[7:0];
        end
      end else if (fmt24[cur]) begin
        out_buf[5'(wr_off)]         <= res[23:16]; // RULE4 RULE3
        out_buf[5'(wr_off + 7'h01)] <= res[15:8];
        out_buf[5'(wr_off + 7'h02)] <= res[7:0];
      end else begin
        out_buf[5'(wr_off)]         <= res[15:8]; // RULE4 RULE3
        out_buf[5'(wr_off + 7'h01)] <= res[7:0];
      end
    end
  end

  // ****************************************
  // completion flags, read port, interrupt
  // ****************************************
  assign flag_set = (done_fire && !burst_on && (force_mask & cur_bit) == 0
                     ? cur_bit : `LCS_NO_CH)
                  | (force_end ? force_mask : `LCS_NO_CH) // RULE12 RULE6
                  | (state == lcs_pkg::lcs_st_flags ? chan_list
                                                    : `LCS_NO_CH); // RULE18
  assign flag_clr = rd_en && addr == `LCS_A_FLAGS ? `LCS_ALL_CH : `LCS_NO_CH;

  // set beats clear, so a completion in the read cycle is not lost
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags <= `LCS_NO_CH;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set; // RULE21 RULE26 RULE23
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      if (addr == `LCS_A_FLAGS) begin
        rdata <= {2'b00, flags}; // RULE23
      end else if (addr >= `LCS_A_OUT_FIRST && addr <= `LCS_A_OUT_LAST) begin
        rdata <= out_buf[5'(addr - `LCS_A_OUT_FIRST)];
      end else if (addr == `LCS_A_RESPONSE) begin
        rdata <= response;
      end else if (addr == `LCS_A_CHAN_LIST) begin
        rdata <= {2'b00, chan_list};
      end else if (addr == `LCS_A_BURST) begin
        rdata <= burst_cfg;
      end else if (addr == `LCS_A_IRQ_EN) begin
        rdata <= {2'b00, irq_en};
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= (flags & irq_en) != `LCS_NO_CH; // RULE20
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_commit;
    state == lcs_pkg::lcs_st_commit ##1 state == lcs_pkg::lcs_st_flags;
  endsequence

  property p_start_enabled;
    @(posedge mclk) disable iff (!nrst)
      meas_req.start |->
        (($past(pending) >> meas_req.chan) & 6'h01) != 6'h00;
  endproperty
  a_start_enabled: assert property (p_start_enabled) // RULE1
    else $error("measurement started for a channel not requested");

  property p_lowest_first;
    @(posedge mclk) disable iff (!nrst)
      meas_req.start |->
        ($past(pending) & ((6'h01 << meas_req.chan) - 6'h01)) == 6'h00;
  endproperty
  a_lowest_first: assert property (p_lowest_first) // RULE17
    else $error("a lower pending channel was skipped");

  property p_fits;
    @(posedge mclk) disable iff (!nrst)
      done_fire && !burst_on |->
        wr_off + (fmt24[cur] ? `LCS_W24 : `LCS_W16) <= 7'(`LCS_NOUT);
  endproperty
  a_fits: assert property (p_fits) // RULE2
    else $error("result placed past the output field");

  property p_msb_first;
    @(posedge mclk) disable iff (!nrst)
      done_fire && !burst_on && !fmt24[cur] && wr_off < 7'h18 |=>
        out_buf[5'($past(wr_off))] == $past(res[15:8]);
  endproperty
  a_msb_first: assert property (p_msb_first) // RULE4
    else $error("most significant byte not at the lowest address");

  property p_burst_flags;
    @(posedge mclk) disable iff (!nrst)
      s_commit |=> (flags & chan_list) == chan_list ##1 irq == |(flags & irq_en);
  endproperty
  a_burst_flags: assert property (p_burst_flags) // RULE18
    else $error("burst end did not flag every enabled channel");

  property p_copy_before_flags;
    @(posedge mclk) disable iff (!nrst)
      state == lcs_pkg::lcs_st_flags |->
        out_buf[0] == shadow[0]
        && out_buf[`LCS_NOUT - 1] == shadow[`LCS_NOUT - 1];
  endproperty
  a_copy_before_flags: assert property (p_copy_before_flags) // RULE19
    else $error("flags moved before burst bytes were copied");

  property p_force_together;
    @(posedge mclk) disable iff (!nrst)
      force_end |=> (flags & $past(force_mask)) == $past(force_mask);
  endproperty
  a_force_together: assert property (p_force_together) // RULE12
    else $error("forced channels not flagged together");

  property p_read_clears;
    @(posedge mclk) disable iff (!nrst)
      rd_en && addr == `LCS_A_FLAGS |=>
        rdata == {2'b00, $past(flags)} && flags == $past(flag_set);
  endproperty
  a_read_clears: assert property (p_read_clears) // RULE21 RULE26
    else $error("flag read did not return then clear the flags");

  property p_irq;
    @(posedge mclk) disable iff (!nrst)
      (flags & irq_en) != 6'h00 |=> irq;
  endproperty
  a_irq: assert property (p_irq) // RULE20
    else $error("interrupt missing for an enabled flagged channel");

  property p_overflow;
    @(posedge mclk) disable iff (!nrst)
      cmd_wr && wdata == `LCS_CMD_START && !auto_on && !burst_on
        && burst_cfg[`LCS_BURST_EN] && burst_need > 14'(`LCS_NOUT)
        |=> response == `LCS_ERR_OVERFLOW ##1 burst_on;
  endproperty
  a_overflow: assert property (p_overflow) // RULE25
    else $error("burst overflow not reported");
endmodule : lcs_scheduler

// ==== tb/lcs_conv_model.sv ====
`timescale 1ns/1ps
// ****************************************
// converter model: answers each start after DELAY cycles
// ****************************************
module lcs_conv_model #(
  parameter int DELAY = 3
) (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire lcs_pkg::lcs_meas_req_type req,
  output lcs_pkg::lcs_meas_ans_type      ans
);
  logic [7:0] seq;
  int         left;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seq  <= 8'h00;
      left <= 0;
      ans  <= '0;
    end else begin
      ans.done   <= 1'b0;
      // result lines toggle when not valid so stale data cannot pass
      ans.result <= ~ans.result;
      if (req.start) begin
        left <= DELAY;
      end else if (left > 0) begin
        left <= left - 1;
        if (left == 1) begin
          ans <= {1'b1, 5'h00, req.chan, seq, seq ^ 8'ha5};
          seq <= seq + 8'h01;
        end
      end
    end
  end
endmodule : lcs_conv_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "lcs_defines.svh"
module testbench;
  logic                      mclk;
  logic                      nrst;
  logic [7:0]                addr;
  logic [7:0]                wdata;
  logic                      wr_en;
  logic                      rd_en;
  logic [7:0]                rdata;
  logic                      irq;
  lcs_pkg::lcs_meas_req_type meas_req;
  lcs_pkg::lcs_meas_ans_type meas_ans;
  int                        errors;
  int                        total_checks;
  int                        cycles;
  // ****************************************
  // instances
  // ****************************************
  lcs_scheduler #(.TICK_CYCLES(4)) i_dut (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .meas_req(meas_req), .meas_ans(meas_ans), .irq(irq));
  lcs_conv_model i_conv (
    .mclk(mclk), .nrst(nrst), .req(meas_req), .ans(meas_ans));
  always #12.5 mclk = ~mclk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic chk_res(input logic [7:0] a, input logic [2:0] ch,
                         input bit w24, input logic [7:0] s);
    logic [23:0] e;
    logic [7:0]  d;
    int          n;
    e = {5'h00, ch, s, s ^ 8'ha5};
    n = w24 ? 3 : 2;
    for (int i = 0; i < n; i++) begin
      rd(a + 8'(i), d);
      check("result byte", d, e[8*(n-1-i) +: 8]);
    end
  endtask : chk_res
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    check("irq raised", irq, 1'b1);
  endtask : wait_irq
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    logic [7:0] d;
    check("irq at reset", irq, 1'b0);
    rd(`LCS_A_RESPONSE, d);
    check("response", d, 8'h0f);
    wr(8'h40, 8'h55);
    rd(8'h40, d);
    check("unmapped", d, 8'h00);
  endtask : t_reset_values
  task automatic t_force();
    logic [7:0] d;
    wr(`LCS_A_CHAN_LIST, 8'h3a);
    wr(`LCS_A_CHCFG0 + 8'h01, 8'h04);
    wr(`LCS_A_CHCFG0 + 8'h04, 8'h04);
    // channel 5 has a rate counter, so force must skip it
    wr(`LCS_A_CHCFG5, 8'h01);
    wr(`LCS_A_PERIOD_L, 8'h01);
    wr(`LCS_A_IRQ_EN, 8'h3f);
    wr(`LCS_A_COMMAND, `LCS_CMD_FORCE);
    wait_irq(300);
    rd(`LCS_A_FLAGS, d);
    check("force flags", d, 8'h1a);
    chk_res(`LCS_A_OUT_FIRST, 3'h1, 1'b1, 8'h00);
    chk_res(`LCS_A_OUT_FIRST + 8'h03, 3'h3, 1'b0, 8'h01);
    chk_res(`LCS_A_OUT_FIRST + 8'h05, 3'h4, 1'b1, 8'h02);
    rd(`LCS_A_FLAGS, d);
    check("flags cleared", d, 8'h00);
    repeat (2) @(posedge mclk);
    #1 check("irq cleared", irq, 1'b0);
  endtask : t_force
  task automatic t_burst();
    logic [7:0] d;
    logic [7:0] b;
    wr(`LCS_A_CHCFG5, 8'h00);
    // three sets of ten bytes cannot fit, so two are kept
    wr(`LCS_A_BURST, 8'h83);
    wr(`LCS_A_COMMAND, `LCS_CMD_START);
    rd(`LCS_A_RESPONSE, d);
    check("overflow code", d, `LCS_ERR_OVERFLOW);
    repeat (40) @(posedge mclk);
    #1 check("irq mid burst", irq, 1'b0);
    // middle byte carries the sequence, so old and new data differ
    rd(`LCS_A_OUT_FIRST + 8'h01, d);
    check("old data mid burst", d, 8'h00);
    wait_irq(2000);
    rd(`LCS_A_FLAGS, d);
    check("burst flags", d, 8'h3a);
    for (int s = 0; s < 2; s++) begin
      b = `LCS_A_OUT_FIRST + 8'(10 * s);
      chk_res(b, 3'h1, 1'b1, 8'(3 + 4 * s));
      chk_res(b + 8'h03, 3'h3, 1'b0, 8'(4 + 4 * s));
      chk_res(b + 8'h05, 3'h4, 1'b1, 8'(5 + 4 * s));
      chk_res(b + 8'h08, 3'h5, 1'b0, 8'(6 + 4 * s));
    end
    wr(`LCS_A_COMMAND, `LCS_CMD_RST_CTR);
    rd(`LCS_A_RESPONSE, d);
    check("response cleared", d, 8'h00);
    wr(`LCS_A_BURST, 8'h00);
  endtask : t_burst
  task automatic t_auto();
    logic [7:0] d;
    int         t0;
    t0 = 0;
    wr(`LCS_A_CHAN_LIST, 8'h01);
    wr(`LCS_A_CHCFG0, 8'h01);
    wr(`LCS_A_COUNT0, 8'h08);
    wr(`LCS_A_COMMAND, `LCS_CMD_START);
    for (int k = 0; k < 2; k++) begin
      wait_irq(2000);
      // eight group events of four cycles, plus alignment and conversion
      if (k == 0) begin
        t0 = cycles;
      end else begin
        check("auto interval", 24'(cycles - t0), 24'h24);
      end
      rd(`LCS_A_FLAGS, d);
      check("auto flags", d, 8'h01);
      chk_res(`LCS_A_OUT_FIRST, 3'h0, 1'b0, 8'(11 + k));
    end
    wr(`LCS_A_COMMAND, `LCS_CMD_PAUSE);
    // a running timer would have tripped again inside this wait
    repeat (60) @(posedge mclk);
    rd(`LCS_A_FLAGS, d);
    check("paused flags", d, 8'h00);
  endtask : t_auto
  initial begin
    mclk   = 1'b0;
    nrst   = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
    wr_en  = 1'b0;
    rd_en  = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_reset_values();
    t_force();
    t_burst();
    t_auto();
    tally_and_finish();
  end
endmodule : testbench
